// file: sarcc_consts.svh
// Constants for the converter sample and conversion control block
`ifndef SARCC_CONSTS_SVH
`define SARCC_CONSTS_SVH
`define SARCC_CLK_HZ        25000000
// Register byte offsets
`define SARCC_CTRL_ADDR     12'h000
`define SARCC_SAMP_ADDR     12'h004
`define SARCC_STAT_ADDR     12'h008
`define SARCC_RESULT_ADDR   12'h00C
// Control register fields
`define SARCC_CTRL_PWR      0
`define SARCC_CTRL_ENC      1
`define SARCC_CTRL_SC       2
`define SARCC_CTRL_REFERENCE_ON    3
`define SARCC_CTRL_REFHI    4
`define SARCC_CTRL_PULSE    5
`define SARCC_CTRL_INV      6
`define SARCC_CTRL_TRIG_LO  8
`define SARCC_CTRL_SSEL_LO  10
`define SARCC_CTRL_DIV_LO   12
`define SARCC_CTRL_SHT_LO   16
`define SARCC_CTRL_PSEL_LO  24
`define SARCC_CTRL_RESET    32'h00000000
// Timing
`define SARCC_CONV_CYCLES   4'hD
`define SARCC_FULL_SCALE    12'hFFF
`define SARCC_FULL_SPAN     13'h0FFF
`define SARCC_REF_SETTLE_MS 17
`endif

// file: sarcc_pkg.sv
// Types for the converter sample and conversion control block
package sarcc_pkg;
  typedef struct packed {
    logic [7:0] pin_sel;
    logic [3:0] sample_time;
    logic [2:0] divider;
    logic [1:0] clk_src;
    logic [1:0] trig_src;
    logic       invert;
    logic       pulse;
    logic       ref_high;
    logic       ref_on;
    logic       enable;
    logic       power;
  } sarcc_ctrl_type;
  typedef struct packed {
    logic [11:0] vin;
    logic [11:0] vref_lo;
    logic [11:0] vref_hi;
  } sarcc_analog_type;
  typedef enum logic [1:0] {
    SARCC_IDLE,
    SARCC_SAMPLE,
    SARCC_CONVERT
  } sarcc_state_type;
endpackage

// file: sarcc_clkdiv.sv
// Conversion clock source selection and divider, as enable pulses
`timescale 1ns/1ps
`include "sarcc_consts.svh"
module sarcc_clkdiv (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] src_tick,
  input  wire logic [1:0] src_sel,
  input  wire logic [2:0] divider,
  output logic            conv_tick
);
  logic [2:0] count_q;
  logic       src_pulse;
  // Source sel: 0 subsystem, 1 master, 2 auxiliary, 3 internal oscillator
  assign src_pulse = src_tick[src_sel]; // [RULE_06]
  // Divide by divider+1 by counting source pulses
  always_ff @(posedge clock) begin
    if (rst) begin
      count_q   <= 3'h0;
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= 1'b0;
      if (src_pulse) begin
        if (count_q >= divider) begin // [RULE_06]
          count_q   <= 3'h0;
          conv_tick <= 1'b1;
        end else begin
          count_q <= count_q + 3'h1;
        end
      end
    end
  end
  // Divide by one on an every-cycle source ticks on every cycle, so check the cause instead
  a_div_spacing: assert property (@(posedge clock) disable iff (rst)
    conv_tick |-> $past(src_pulse && (count_q >= divider)))
    else $error("conversion tick without divider terminal count"); // [RULE_06]
endmodule // sarcc_clkdiv

// file: sarcc_sar_core.sv
// Successive-approximation core model of thirteen conversion steps
`timescale 1ns/1ps
`include "sarcc_consts.svh"
module sarcc_sar_core (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      start,
  input  wire logic                      step,
  input  wire logic                      powered,
  input  wire sarcc_pkg::sarcc_analog_type analog,
  output logic                           busy,
  output logic                           done,
  output logic [11:0]                    result
);
  logic [3:0]  step_q;
  logic [11:0] code;
  logic [23:0] num;
  logic [12:0] span;
  // Transfer function: clamp at references, else 4095*(vin-lo)/(hi-lo)
  always_comb begin
    num  = 24'h000000;
    span = 13'h0000;
    code = 12'h000;
    if (analog.vin >= analog.vref_hi) begin
      code = `SARCC_FULL_SCALE; // [RULE_01]
    end else if (analog.vin <= analog.vref_lo) begin
      code = 12'h000; // [RULE_01]
    end else begin
      span = {1'b0, analog.vref_hi - analog.vref_lo};
      num  = 24'(analog.vin - analog.vref_lo) * 24'(`SARCC_FULL_SPAN); // [RULE_02]
      code = 12'(num / 24'(span)); // [RULE_02]
    end
  end
  // Thirteen conversion clock steps; result only on the last step
  always_ff @(posedge clock) begin
    if (rst || !powered) begin
      step_q <= 4'h0;
      busy   <= 1'b0;
      done   <= 1'b0;
      result <= 12'h000;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy   <= 1'b1;
        step_q <= 4'h0;
      end else if (busy && step) begin // [RULE_07]
        if (step_q == `SARCC_CONV_CYCLES - 4'h1) begin // [RULE_16]
          busy   <= 1'b0;
          done   <= 1'b1;
          result <= code;
        end
        step_q <= step_q + 4'h1;
      end
    end
  end
  a_conv_length: assert property (@(posedge clock) disable iff (rst)
    $rose(busy) |-> busy [*2]) else $error("conversion ended too soon"); // [RULE_16]
endmodule // sarcc_sar_core

// file: sarcc_top.sv
// Converter sample and conversion control with APB register slave
//
// How it works
// [RULE_01] Clamp result at full scale or zero
// [RULE_02] Result scales 4095 over reference span
// [RULE_03] Core powered only when power bit set
// [RULE_04] Most control bits frozen while enabled
// [RULE_05] No conversion unless enable bit set
// [RULE_06] Four clock sources, divide one to eight
// [RULE_07] Divided clock steps conversion and pulse timer
// [RULE_08] Clock must run until conversion ends
// [RULE_09] Analog pin select disables digital buffers
// [RULE_10] Reference on bit enables internal reference
// [RULE_11] Reference level 2.5 or 1.5 volts
// [RULE_12] Software waits for reference settling
// [RULE_13] Rising trigger edge starts sampling
// [RULE_14] Four trigger sources selectable
// [RULE_15] Invert bit flips trigger polarity
// [RULE_16] Window fall starts 13-cycle conversion
// [RULE_17] Extended mode window follows trigger
// [RULE_18] Extended window fall synchronized first
// [RULE_19] Pulse mode holds window 4x cycles
// [RULE_20] Trigger synchronized by two stages
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "sarcc_consts.svh"
module sarcc_top (
  input  wire logic                        clock,
  input  wire logic                        rst,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  // Clock source ticks: subsystem, master, auxiliary, internal oscillator
  input  wire logic [3:0]                  src_tick,
  // Timer outputs: first timer unit 1, second timer units 0 and 1
  input  wire logic                        timer1_out1,
  input  wire logic                        timer2_out0,
  input  wire logic                        timer2_out1,
  // Analog levels seen by the core
  input  wire sarcc_pkg::sarcc_analog_type analog,
  // Analog side controls
  output logic                             core_power,
  output logic                             ref_enable,
  output logic                             ref_level_high,
  output logic                             sample_window,
  output logic                             conv_busy,
  output logic [7:0]                       pin_digital_off,
  output logic [11:0]                      conversion_result
);
  sarcc_pkg::sarcc_ctrl_type ctrl_q;
  sarcc_pkg::sarcc_state_type state_q;
  logic        sw_start_q;
  logic        conv_tick;
  logic        core_busy;
  logic        core_done;
  logic [11:0] core_result;
  logic        trig_raw;
  logic        trig_s1_q;
  logic        trig_s2_q;
  logic        trig_prev_q;
  logic        trig_rise;
  logic        trig_fall;
  logic        conv_start_q;
  logic [5:0]  samp_count_q;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] samp_reg;

  // ********************************************
  // APB register access
  // ********************************************

  // Decode a register offset once, used for reads and writes
  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
    is_addr = (a == off);
  endfunction

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;
  assign samp_reg = 32'h00000000;

  // Zero wait states: pready raised during every access phase
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // Unmapped offsets answer with an error
  always_ff @(posedge clock) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !is_addr(paddr, `SARCC_CTRL_ADDR)
                 && !is_addr(paddr, `SARCC_STAT_ADDR)
                 && !is_addr(paddr, `SARCC_RESULT_ADDR);
    end
  end

  // Read data captured in the setup cycle, held through the access
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      if (is_addr(paddr, `SARCC_CTRL_ADDR)) begin
        prdata <= {ctrl_q.pin_sel, 4'h0, ctrl_q.sample_time, 1'b0, ctrl_q.divider,
                   ctrl_q.clk_src, ctrl_q.trig_src, 1'b0, ctrl_q.invert,
                   ctrl_q.pulse, ctrl_q.ref_high, ctrl_q.ref_on, 1'b0,
                   ctrl_q.enable, ctrl_q.power};
      end else if (is_addr(paddr, `SARCC_STAT_ADDR)) begin
        prdata <= {29'h00000000, sample_window, core_busy, trig_s2_q};
      end else if (is_addr(paddr, `SARCC_RESULT_ADDR)) begin
        prdata <= {20'h00000, conversion_result};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // Control register; configuration fields except ref_on and pin_sel frozen while enabled
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= sarcc_pkg::sarcc_ctrl_type'(25'h0000000);
    end else if (wr_en && is_addr(paddr, `SARCC_CTRL_ADDR)) begin
      ctrl_q.power    <= ctrl_q.enable ? ctrl_q.power : pwdata[`SARCC_CTRL_PWR]; // [RULE_04]
      ctrl_q.enable   <= pwdata[`SARCC_CTRL_ENC];
      ctrl_q.ref_on   <= pwdata[`SARCC_CTRL_REFERENCE_ON];
      ctrl_q.pin_sel  <= pwdata[`SARCC_CTRL_PSEL_LO +: 8];
      if (!ctrl_q.enable) begin // [RULE_04]
        ctrl_q.ref_high    <= pwdata[`SARCC_CTRL_REFHI];
        ctrl_q.pulse       <= pwdata[`SARCC_CTRL_PULSE];
        ctrl_q.invert      <= pwdata[`SARCC_CTRL_INV];
        ctrl_q.trig_src    <= pwdata[`SARCC_CTRL_TRIG_LO +: 2];
        ctrl_q.clk_src     <= pwdata[`SARCC_CTRL_SSEL_LO +: 2];
        ctrl_q.divider     <= pwdata[`SARCC_CTRL_DIV_LO +: 3];
        ctrl_q.sample_time <= pwdata[`SARCC_CTRL_SHT_LO +: 4];
      end
    end
  end

  // Software start bit: pulses high for one sampling trigger, cleared
  // by hardware when the window closes so a new write can retrigger
  always_ff @(posedge clock) begin
    if (rst) begin
      sw_start_q <= 1'b0;
    end else if (wr_en && is_addr(paddr, `SARCC_CTRL_ADDR) && pwdata[`SARCC_CTRL_SC]) begin
      sw_start_q <= 1'b1;
    end else if (conv_start_q || !ctrl_q.enable) begin
      sw_start_q <= 1'b0;
    end
  end

  // ********************************************
  // Analog side controls
  // ********************************************

  // Power, reference and pin buffer controls straight from flops
  always_ff @(posedge clock) begin
    if (rst) begin
      core_power      <= 1'b0;
      ref_enable      <= 1'b0;
      ref_level_high  <= 1'b0;
      pin_digital_off <= 8'h00;
    end else begin
      core_power      <= ctrl_q.power; // [RULE_03]
      ref_enable      <= ctrl_q.ref_on; // [RULE_10]
      ref_level_high  <= ctrl_q.ref_high; // [RULE_11]
      pin_digital_off <= ctrl_q.pin_sel; // [RULE_09]
    end
  end

  // ********************************************
  // Trigger selection and synchronization
  // ********************************************

  // Source choice then optional inversion before synchronizing
  always_comb begin
    unique case (ctrl_q.trig_src) // [RULE_14]
      2'h0: trig_raw = sw_start_q;
      2'h1: trig_raw = timer1_out1;
      2'h2: trig_raw = timer2_out0;
      2'h3: trig_raw = timer2_out1;
    endcase
    trig_raw = trig_raw ^ ctrl_q.invert; // [RULE_15]
  end

  // Three stages on conversion clock ticks; edges from stages two and three
  always_ff @(posedge clock) begin
    if (rst) begin
      trig_s1_q   <= 1'b0;
      trig_s2_q   <= 1'b0;
      trig_prev_q <= 1'b0;
    end else if (conv_tick) begin
      trig_s1_q   <= trig_raw; // [RULE_20]
      trig_s2_q   <= trig_s1_q; // [RULE_20]
      trig_prev_q <= trig_s2_q;
    end
  end

  assign trig_rise = conv_tick && trig_s2_q && !trig_prev_q; // [RULE_13]
  assign trig_fall = conv_tick && !trig_s2_q && trig_prev_q; // [RULE_18]

  // ********************************************
  // Sample window and conversion start
  // ********************************************

  // Window state: sampling, then 13-step conversion in the core.
  // A stopped conversion clock stalls here and the result never lands.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q      <= sarcc_pkg::SARCC_IDLE;
      samp_count_q <= 6'h00;
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      unique case (state_q)
        sarcc_pkg::SARCC_IDLE: begin
          if (trig_rise && ctrl_q.enable && ctrl_q.power) begin // [RULE_05]
            state_q      <= sarcc_pkg::SARCC_SAMPLE;
            samp_count_q <= {ctrl_q.sample_time, 2'h3}; // [RULE_19]
          end
        end
        sarcc_pkg::SARCC_SAMPLE: begin
          if (!ctrl_q.enable || !ctrl_q.power) begin
            state_q <= sarcc_pkg::SARCC_IDLE;
          end else if (ctrl_q.pulse) begin
            if (conv_tick) begin // [RULE_07]
              if (samp_count_q == 6'h00) begin
                state_q      <= sarcc_pkg::SARCC_CONVERT;
                conv_start_q <= 1'b1; // [RULE_16]
              end else begin
                samp_count_q <= samp_count_q - 6'h01;
              end
            end
          end else if (trig_fall) begin // [RULE_17]
            state_q      <= sarcc_pkg::SARCC_CONVERT;
            conv_start_q <= 1'b1; // [RULE_18]
          end
        end
        sarcc_pkg::SARCC_CONVERT: begin
          if (core_done || !ctrl_q.power) begin // [RULE_08]
            state_q <= sarcc_pkg::SARCC_IDLE;
          end
        end
        default: state_q <= sarcc_pkg::SARCC_IDLE;
      endcase
    end
  end

  // Window and status outputs registered
  always_ff @(posedge clock) begin
    if (rst) begin
      sample_window     <= 1'b0;
      conv_busy         <= 1'b0;
      conversion_result <= 12'h000;
    end else begin
      sample_window <= (state_q == sarcc_pkg::SARCC_SAMPLE) && !conv_start_q; // [RULE_17]
      conv_busy     <= (state_q != sarcc_pkg::SARCC_IDLE);
      if (core_done) begin
        conversion_result <= core_result; // [RULE_02]
      end
    end
  end

  // ********************************************
  // Clock divider and converter core
  // ********************************************

  sarcc_clkdiv u_clkdiv (
    .clock     (clock),
    .rst       (rst),
    .src_tick  (src_tick),
    .src_sel   (ctrl_q.clk_src),
    .divider   (ctrl_q.divider),
    .conv_tick (conv_tick)
  );

  sarcc_sar_core u_core (
    .clock   (clock),
    .rst     (rst),
    .start   (conv_start_q),
    .step    (conv_tick),
    .powered (ctrl_q.power), // [RULE_03]
    .analog  (analog),
    .busy    (core_busy),
    .done    (core_done),
    .result  (core_result)
  );

  a_no_conv_off: assert property (@(posedge clock) disable iff (rst)
    conv_start_q |-> ctrl_q.enable) else $error("conversion without enable"); // [RULE_05]
  a_power_follow: assert property (@(posedge clock) disable iff (rst)
    ##1 core_power == $past(ctrl_q.power)) else $error("power not following"); // [RULE_03]
  a_ref_follow: assert property (@(posedge clock) disable iff (rst)
    ##1 ref_enable == $past(ctrl_q.ref_on)) else $error("reference not following"); // [RULE_10]
  a_cfg_frozen: assert property (@(posedge clock) disable iff (rst)
    ctrl_q.enable |=> $stable(ctrl_q.divider)) else $error("config changed while on"); // [RULE_04]
  a_ext_start: assert property (@(posedge clock) disable iff (rst)
    (state_q == sarcc_pkg::SARCC_SAMPLE && !ctrl_q.pulse && ctrl_q.enable && ctrl_q.power
     && trig_fall) |=> conv_start_q) else $error("extended start missed"); // [RULE_18]
  a_clamp_high: assert property (@(posedge clock) disable iff (rst)
    (core_done && $past(analog.vin >= analog.vref_hi) && $past(analog) == analog)
    |-> core_result == `SARCC_FULL_SCALE) else $error("high clamp wrong"); // [RULE_01]
endmodule // sarcc_top

// file: sarcc_analog_model.sv
// Sample-and-hold and reference model of the analog side of the block
`timescale 1ns/1ps
module sarcc_analog_model #(
  parameter int SETTLE_CYCLES = 64
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   sample_window,
  input  wire logic                   ref_enable,
  input  wire logic [11:0]            vin_src,
  input  wire logic [11:0]            lo_src,
  input  wire logic [11:0]            hi_src,
  output sarcc_pkg::sarcc_analog_type analog,
  output logic                        ref_ready
);
  // ************
  // Analog side
  // ************
  int settle_q;

  // Input tracked only while the window is open, then held for the conversion
  always_ff @(posedge clock) begin
    if (rst) begin
      analog <= '0;
    end else begin
      if (sample_window) begin
        analog.vin <= vin_src;
      end
      analog.vref_lo <= lo_src;
      analog.vref_hi <= hi_src;
    end
  end

  // Reference settling, shortened so software still has to wait for it
  always_ff @(posedge clock) begin
    if (rst || !ref_enable) begin
      settle_q <= 0;
    end else if (settle_q < SETTLE_CYCLES) begin
      settle_q <= settle_q + 1;
    end
  end
  assign ref_ready = (settle_q >= SETTLE_CYCLES);
endmodule // sarcc_analog_model

// file: tb.sv
// Self-checking bench for the converter sample and conversion control block
`timescale 1ns/1ps
`include "sarcc_consts.svh"
module tb;
  // ******************
  // Bench and stimulus
  // ******************
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] src_tick = 4'h0;
  logic [3:0] ph = 4'h0;
  logic timer1_out1 = 1'b0;
  logic timer2_out0 = 1'b0;
  logic timer2_out1 = 1'b0;
  logic [11:0] vin_src = 12'h000;
  logic [11:0] lo_src = 12'h000;
  logic [11:0] hi_src = 12'hFFF;
  logic pready, pslverr, core_power, ref_enable, ref_level_high;
  logic sample_window, conv_busy, ref_ready, rerr;
  logic [31:0] prdata, rdat;
  logic [7:0] pin_digital_off;
  logic [11:0] conversion_result;
  sarcc_pkg::sarcc_analog_type analog;
  int failures = 0;
  int checked = 0;
  int n;
  // Clamp and exact-scale cases: input, low and high reference, expected code
  logic [11:0] cv [6] = '{12'h123, 12'h900, 12'h080, 12'h800, 12'h100, 12'hABC};
  logic [11:0] cl [6] = '{12'h000, 12'h100, 12'h100, 12'h100, 12'h100, 12'h000};
  logic [11:0] ch [6] = '{12'hFFF, 12'h800, 12'h800, 12'h800, 12'h800, 12'hFFF};
  logic [11:0] ce [6] = '{12'h123, 12'hFFF, 12'h000, 12'hFFF, 12'h000, 12'hABC};

  sarcc_top dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .src_tick(src_tick), .timer1_out1(timer1_out1),
    .timer2_out0(timer2_out0), .timer2_out1(timer2_out1), .analog(analog),
    .core_power(core_power), .ref_enable(ref_enable), .ref_level_high(ref_level_high),
    .sample_window(sample_window), .conv_busy(conv_busy),
    .pin_digital_off(pin_digital_off), .conversion_result(conversion_result));
  sarcc_analog_model model_u (.clock(clock), .rst(rst), .sample_window(sample_window),
    .ref_enable(ref_enable), .vin_src(vin_src), .lo_src(lo_src), .hi_src(hi_src),
    .analog(analog), .ref_ready(ref_ready));

  always #20 clock = ~clock;
  // Sources tick every 1, 2, 3, 4 cycles so the chosen source shows in the timing
  always @(posedge clock) begin
    ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
    src_tick <= {ph % 4 == 0, ph % 3 == 0, ph % 2 == 0, 1'b1};
  end

  function automatic logic [31:0] mk(input logic en, sc, reference_on, refhi, pulse, inv,
    input logic [1:0] trig, ssel, input logic [2:0] dv, input logic [3:0] sht,
    input logic [7:0] pins);
    mk = {pins, 4'h0, sht, 1'b0, dv, ssel, trig, 1'b0, inv, pulse, refhi, reference_on, sc, en, 1'b1};
  endfunction

  task automatic summarize();
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held from setup until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      failures++;
      summarize();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait on the window (w=0) or busy (w=1) output
  task automatic wait_for(input int w, input logic v, output int c);
    c = 0;
    while ((w ? conv_busy : sample_window) !== v) begin
      @(posedge clock);
      c++;
      if (c > 3000) begin
        failures++;
        summarize();
      end
    end
  endtask

  task automatic set_pin(input int t, input logic v);
    case (t)
      1: timer1_out1 <= v;
      2: timer2_out0 <= v;
      default: timer2_out1 <= v;
    endcase
  endtask

  // Pulse-mode software conversion on source s with divider d
  task automatic run(input int s, input int d, input int k);
    int p, c, sh;
    p = (s + 1) * (d + 1);
    sh = d % 2;
    vin_src <= cv[k];
    lo_src <= cl[k];
    hi_src <= ch[k];
    apb(1'b1, `SARCC_CTRL_ADDR, 32'h00000001);
    apb(1'b1, `SARCC_CTRL_ADDR, mk(0, 0, 0, 0, 1, 0, 2'd0, 2'(s), 3'(d), 4'(sh), 8'h00));
    apb(1'b1, `SARCC_CTRL_ADDR, mk(1, 1, 0, 0, 1, 0, 2'd0, 2'(s), 3'(d), 4'(sh), 8'h00));
    wait_for(0, 1'b1, c);
    wait_for(0, 1'b0, c);
    check(32'(c >= 4 * p * (sh + 1) - p && c <= 4 * p * (sh + 1) + p), 32'h1);
    wait_for(1, 1'b0, c);
    check(32'(c >= 12 * p && c <= 14 * p + 2), 32'h1);
    @(posedge clock);
    check(32'(conversion_result), 32'(ce[k]));
    apb(1'b0, `SARCC_RESULT_ADDR, 32'h0);
    check(rdat, 32'(ce[k]));
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    check({core_power, ref_enable, sample_window, conv_busy, 20'(conversion_result)}, 0);
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    apb(1'b0, 12'h004, 32'h0);
    check({31'h00000000, rerr}, 32'h00000001);
    check(rdat, 32'h00000000);
    apb(1'b0, `SARCC_CTRL_ADDR, 32'h0);
    check(rdat, `SARCC_CTRL_RESET);
    // Control bits reach the analog side; frozen fields hold while enabled
    apb(1'b1, `SARCC_CTRL_ADDR, mk(0, 0, 1, 1, 0, 0, 2'd0, 2'd0, 3'd2, 4'h0, 8'h5A));
    repeat (2) @(posedge clock);
    check({core_power, ref_enable, ref_level_high, pin_digital_off}, 11'h75A);
    apb(1'b1, `SARCC_CTRL_ADDR, mk(1, 0, 1, 1, 0, 0, 2'd0, 2'd0, 3'd2, 4'h0, 8'h5A));
    apb(1'b1, `SARCC_CTRL_ADDR, mk(1, 0, 1, 0, 1, 1, 2'd3, 2'd1, 3'd5, 4'h7, 8'hA5));
    apb(1'b0, `SARCC_CTRL_ADDR, 32'h0);
    check(rdat, mk(1, 0, 1, 1, 0, 0, 2'd0, 2'd0, 3'd2, 4'h0, 8'hA5));
    @(posedge clock);
    check({ref_enable, ref_level_high, pin_digital_off}, 10'h3A5);
    n = 0;
    while (ref_ready !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    check(32'(ref_ready), 32'h1);
    // Power is frozen while enabled, so enable is cleared first
    apb(1'b1, `SARCC_CTRL_ADDR, 32'h00000001);
    apb(1'b1, `SARCC_CTRL_ADDR, 32'h00000000);
    repeat (2) @(posedge clock);
    check({core_power, ref_enable}, 0);
    // Software start with enable clear must not convert
    apb(1'b1, `SARCC_CTRL_ADDR, mk(0, 1, 0, 0, 1, 0, 2'd0, 2'd0, 3'd0, 4'h0, 8'h00));
    repeat (60) @(posedge clock);
    check({sample_window, conv_busy}, 0);
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 8; d++) begin
        run(s, d, (s * 8 + d) % 6);
      end
    end
    // Extended mode on each timer trigger, both polarities
    for (int t = 1; t < 4; t++) begin
      for (int v = 0; v < 2; v++) begin
        apb(1'b1, `SARCC_CTRL_ADDR, 32'h00000001);
        apb(1'b1, `SARCC_CTRL_ADDR, mk(0, 0, 0, 0, 0, v[0], 2'(t), 2'd0, 3'd0, 4'h0, 8'h00));
        set_pin(t, v[0]);
        repeat (8) @(posedge clock);
        apb(1'b1, `SARCC_CTRL_ADDR, mk(1, 0, 0, 0, 0, v[0], 2'(t), 2'd0, 3'd0, 4'h0, 8'h00));
        set_pin(t, !v[0]);
        wait_for(0, 1'b1, n);
        check(32'(n >= 2 && n <= 6), 32'h1);
        repeat (40) @(posedge clock);
        check(32'(sample_window), 32'h1);
        // Status while sampling: window open, core idle, synced trigger high
        apb(1'b0, `SARCC_STAT_ADDR, 32'h0);
        check(rdat, 32'h00000005);
        set_pin(t, v[0]);
        wait_for(0, 1'b0, n);
        check(32'(n >= 2 && n <= 6), 32'h1);
        wait_for(1, 1'b0, n);
        check(32'(n >= 12 && n <= 15), 32'h1);
        @(posedge clock);
        check(32'(conversion_result), 32'(ce[k_last()]));
      end
    end
    summarize();
  end

  // Case used by the last pulse-mode run, still loaded in the analog model
  function automatic int k_last();
    k_last = (3 * 8 + 7) % 6;
  endfunction
endmodule // tb
